//--- rtl/ceif_pkg.sv
package ceif_pkg;

  // APB geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_BUF = 32;
  localparam int unsigned BUF_IDX_W = 5;
  localparam int unsigned FILT_W = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_TX_MASK = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_LAST_STORE = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_BUF_BASE = 12'h080;
  localparam logic [ADDR_W-1:0] OFF_BUF_LAST = 12'h0FC;

  // Interrupt flag register field positions
  localparam int unsigned POS_TX_BUS_OFF = 13;
  localparam int unsigned POS_TX_PASSIVE = 12;
  localparam int unsigned POS_RX_PASSIVE = 11;
  localparam int unsigned POS_TX_WARNING = 10;
  localparam int unsigned POS_RX_WARNING = 9;
  localparam int unsigned POS_ANY_WARNING = 8;
  localparam int unsigned POS_INVALID = 7;
  localparam int unsigned POS_WAKEUP = 6;
  localparam int unsigned POS_ERROR = 5;
  localparam int unsigned POS_FIFO_AF = 3;
  localparam int unsigned POS_RX_OVF = 2;
  localparam int unsigned POS_RX_BUF = 1;
  localparam int unsigned POS_TX_BUF = 0;

  // Sticky flag bits that software may clear, reset value
  localparam logic [7:0] FLAG_IMPL_MASK = 8'hEF;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // Buffer status word: filter index field
  localparam int unsigned POS_FILT_LO = 8;
  localparam logic [FILT_W-1:0] FILT_RESET = 5'h00;
  localparam logic [NUM_BUF-1:0] TX_MASK_RESET = 32'h00000000;

  // Last store register fields
  localparam int unsigned POS_LAST_BUF_LO = 8;
  localparam int unsigned POS_LAST_VALID = 16;

  typedef struct packed {
    logic tx_bus_off;
    logic tx_passive;
    logic rx_passive;
    logic tx_warning;
    logic rx_warning;
  } ceif_err_state_s;

  typedef struct packed {
    logic invalid_msg;
    logic wakeup;
    logic fifo_almost_full;
    logic rx_overflow;
    logic rx_buffer;
    logic tx_buffer;
  } ceif_events_s;

  typedef struct packed {
    logic valid;
    logic [BUF_IDX_W-1:0] buf_idx;
    logic [FILT_W-1:0] filter;
  } ceif_store_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } ceif_apb_e;

endpackage : ceif_pkg

//--- rtl/ceif_status.sv
`timescale 1ns/1ns
// Function
// - tx_bus_off_flag is high exactly while the transmitter is bus off.
// - tx_bus_passive_flag is high exactly while the transmitter is error passive.
// - rx_bus_passive_flag is high exactly while the receiver is error passive.
// - tx_warning_flag is high exactly while the transmitter is in error warning.
// - rx_warning_flag is high exactly while the receiver is in error warning.
// - any_warning_flag is the OR of the two warning conditions.
// - invalid_message_irq is set when an invalid message is received.
// - wakeup_activity_irq is set when bus wake-up activity is detected.
// - error_summary_irq is set by the error-state conditions of bits 13 to 8.
// - fifo_almost_full_irq is set when the receive FIFO becomes almost full.
// - rx_overflow_irq is set when a received message overflows the buffers.
// - rx_buffer_irq is set when a message is placed in a receive buffer.
// - tx_buffer_irq is set on a transmit buffer event.
// - Flag register bits 15, 14 and 4 always read zero.
// - A stored message records its filter number in that buffer's index field.
// - The index field is written by hardware only for receive buffers.
// - Thirty-two buffer status words; bits 15 to 13 and 7 to 0 read zero.
// - Interrupt flags reset to zero, software reads and clears; state bits read-only.
module ceif_status
  import ceif_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Error confinement state from the error counters
  input wire ceif_err_state_s err_state,
  // One-cycle event pulses from the frame engine
  input wire ceif_events_s events,
  // Receive store notification
  input wire ceif_store_s store,
  // Sticky flags for the interrupt controller
  output logic [7:0] irq_flags
);

  ////////////////////////////////////////////////////////////////////////////
  // Local signals

  ceif_apb_e apb_q;
  ceif_apb_e apb_d;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;

  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [5:0] err_prev_q;
  logic [5:0] err_prev_d;

  logic [NUM_BUF-1:0] tx_mask_q;
  logic [NUM_BUF-1:0] tx_mask_d;
  logic [FILT_W-1:0] filt_q [NUM_BUF];

  logic [BUF_IDX_W-1:0] last_buf_q;
  logic [BUF_IDX_W-1:0] last_buf_d;
  logic [FILT_W-1:0] last_filt_q;
  logic [FILT_W-1:0] last_filt_d;
  logic last_valid_q;
  logic last_valid_d;

  logic setup;
  logic wr_access;
  logic sel_flags;
  logic sel_tx_mask;
  logic sel_last;
  logic sel_buf;
  logic [BUF_IDX_W-1:0] buf_sel;
  logic [5:0] err_now;
  logic err_rise;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [15:0] flags_view;
  logic hw_store;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite && pready;
  assign sel_flags = (paddr == OFF_FLAGS);
  assign sel_tx_mask = (paddr == OFF_TX_MASK);
  assign sel_last = (paddr == OFF_LAST_STORE);
  assign sel_buf = (paddr >= OFF_BUF_BASE) && (paddr <= OFF_BUF_LAST)
                   && (paddr[1:0] == 2'h0);
  assign buf_sel = paddr[BUF_IDX_W+1:2];

  ////////////////////////////////////////////////////////////////////////////
  // Error state view, combinational so it never lags the counters

  assign err_now = {
    err_state.tx_bus_off,
    err_state.tx_passive,
    err_state.rx_passive,
    err_state.tx_warning,
    err_state.rx_warning,
    err_state.tx_warning | err_state.rx_warning
  };

  // Entering any error state raises the summary request once per entry
  assign err_rise = |(err_now & ~err_prev_q);

  always_comb begin
    err_prev_d = err_now;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt flags

  always_comb begin
    flag_set = 8'h00;
    flag_set[POS_INVALID] = events.invalid_msg;
    flag_set[POS_WAKEUP] = events.wakeup;
    flag_set[POS_ERROR] = err_rise;
    flag_set[POS_FIFO_AF] = events.fifo_almost_full;
    flag_set[POS_RX_OVF] = events.rx_overflow;
    flag_set[POS_RX_BUF] = events.rx_buffer;
    flag_set[POS_TX_BUF] = events.tx_buffer;
  end

  // Writing a zero clears a flag, writing a one leaves it alone
  always_comb begin
    flag_clr = 8'h00;
    if (wr_access && sel_flags) begin
      flag_clr = ~pwdata[7:0];
    end
  end

  // Set applied after clear so a same-cycle event is never lost
  always_comb begin
    flags_d = ((flags_q & ~flag_clr) | flag_set) & FLAG_IMPL_MASK;
  end

  assign flags_view = {2'h0, err_now, flags_q};
  assign irq_flags = flags_q;

  ////////////////////////////////////////////////////////////////////////////
  // Buffer direction, filter index words and last-store record

  assign hw_store = store.valid && !tx_mask_q[store.buf_idx];

  // Software marks transmit buffers, so a hardware store never overwrites their index word
  always_comb begin
    tx_mask_d = tx_mask_q;
    if (wr_access && sel_tx_mask) begin
      tx_mask_d = pwdata[NUM_BUF-1:0];
    end
  end

  // One word per buffer; a hardware store wins over a software write to it
  for (genvar g = 0; g < NUM_BUF; g++) begin : g_filt
    logic sw_hit;
    logic hw_hit;
    logic [FILT_W-1:0] word_q;
    logic [FILT_W-1:0] word_d;

    assign sw_hit = wr_access && sel_buf && (buf_sel == BUF_IDX_W'(g));
    assign hw_hit = hw_store && (store.buf_idx == BUF_IDX_W'(g));

    always_comb begin
      word_d = word_q;
      if (hw_hit) begin
        word_d = store.filter;
      end else if (sw_hit) begin
        word_d = pwdata[POS_FILT_LO +: FILT_W];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        word_q <= FILT_RESET;
      end else begin
        word_q <= word_d;
      end
    end

    assign filt_q[g] = word_q;
  end

  // A write to the last-store register drops valid, so software can wait for the next store
  always_comb begin
    last_buf_d = last_buf_q;
    last_filt_d = last_filt_q;
    last_valid_d = last_valid_q;
    if (hw_store) begin
      last_buf_d = store.buf_idx;
      last_filt_d = store.filter;
      last_valid_d = 1'b1;
    end else if (wr_access && sel_last) begin
      last_valid_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB phase and read data
  // Read data is captured in the setup cycle, so the access phase
  // answers at once while prdata still comes from a flip-flop.

  always_comb begin
    apb_d = apb_q;
    unique case (apb_q)
      ST_IDLE: begin
        if (setup) begin
          apb_d = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (!setup) begin
          apb_d = ST_IDLE;
        end
      end
      default: begin
        apb_d = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setup) begin
      prdata_d = '0;
      pslverr_d = 1'b0;
      if (sel_flags) begin
        prdata_d[15:0] = flags_view;
      end else if (sel_tx_mask) begin
        prdata_d[NUM_BUF-1:0] = tx_mask_q;
      end else if (sel_last) begin
        prdata_d[FILT_W-1:0] = last_filt_q;
        prdata_d[POS_LAST_BUF_LO +: BUF_IDX_W] = last_buf_q;
        prdata_d[POS_LAST_VALID] = last_valid_q;
      end else if (sel_buf) begin
        prdata_d[POS_FILT_LO +: FILT_W] = filt_q[buf_sel];
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  assign pready = (apb_q == ST_ACCESS);
  assign prdata = prdata_q;
  assign pslverr = pslverr_q && pready;

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  // Bus phase, read data and error response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_q <= ST_IDLE;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else begin
      apb_q <= apb_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Sticky interrupt flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= FLAG_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Error state of the previous cycle, cleared so a state already present after reset counts as an entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_prev_q <= 6'h00;
    end else begin
      err_prev_q <= err_prev_d;
    end
  end

  // Transmit buffer mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_mask_q <= TX_MASK_RESET;
    end else begin
      tx_mask_q <= tx_mask_d;
    end
  end

  // Last accepted store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_buf_q <= '0;
      last_filt_q <= FILT_RESET;
      last_valid_q <= 1'b0;
    end else begin
      last_buf_q <= last_buf_d;
      last_filt_q <= last_filt_d;
      last_valid_q <= last_valid_d;
    end
  end

endmodule : ceif_status

//--- bench/ceif_status_properties.sv
`timescale 1ns/1ns
module ceif_status_properties
  import ceif_pkg::*;
(
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Engine side
  input wire ceif_err_state_s err_state,
  input wire ceif_events_s events,
  input wire ceif_store_s store,
  input wire logic [7:0] irq_flags
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_flags;
  logic [7:0] clr;
  logic [7:0] evmap;
  logic [4:0] seen_err_q;
  logic err_up;
  // Entry into an error state sets the summary flag like any other event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_err_q <= '0;
    end else begin
      seen_err_q <= err_state;
    end
  end
  assign err_up = |(err_state & ~seen_err_q);
  assign wr_flags = psel && penable && pready && pwrite && (paddr == OFF_FLAGS);
  assign clr = wr_flags ? ~pwdata[7:0] : 8'h00;
  assign evmap = {events.invalid_msg, events.wakeup, err_up, 1'b0, events.fifo_almost_full,
    events.rx_overflow, events.rx_buffer, events.tx_buffer};
  rd_flags_a: assert property (
    psel && !penable && !pwrite && paddr == OFF_FLAGS |=> prdata == {16'h0000, 2'b00,
    $past(err_state), $past(err_state.tx_warning) | $past(err_state.rx_warning),
    $past(irq_flags)})
    else $error("flag register read wrong");
  event_set_a: assert property (
    ($past(evmap) & ~irq_flags) == 8'h00) else $error("event flag not set");
  err_summary_a: assert property (
    |(err_state & ~$past(err_state)) |=> irq_flags[POS_ERROR]) else $error("error flag not set");
  gap_zero_a: assert property (!irq_flags[4]) else $error("flag bit 4 set");
  flag_sticky_a: assert property (
    ($past(irq_flags) & ~irq_flags & ~$past(clr)) == 8'h00) else $error("flag dropped");
  flag_clear_a: assert property (
    wr_flags |=> (irq_flags & $past(clr) & ~$past(evmap)) == 8'h00)
    else $error("flag not cleared");
  ready_access_a: assert property (pready == (psel && penable)) else $error("pready misplaced");
  unmapped_err_a: assert property (
    psel && !penable && paddr > OFF_BUF_LAST |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access accepted");
endmodule : ceif_status_properties

bind ceif_status ceif_status_properties i_ceif_status_properties (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .err_state, .events,
  .store, .irq_flags);

//--- bench/ceif_engine.sv
`timescale 1ns/1ns
module ceif_engine
  import ceif_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Toward the status block
  output ceif_err_state_s err_state,
  output ceif_events_s events,
  output ceif_store_s store
);
  initial begin
    err_state = '0;
    events = '0;
    store = '0;
  end
  // Strobes last one cycle; stale index and filter are inverted, never left showing
  task pulse(input ceif_events_s e);
    @(posedge pclk);
    events <= e;
    @(posedge pclk);
    events <= '0;
  endtask : pulse
  task put(input logic [4:0] b, input logic [4:0] f);
    @(posedge pclk);
    store <= '{1'b1, b, f};
    @(posedge pclk);
    store <= '{1'b0, ~b, ~f};
  endtask : put
  task set_state(input ceif_err_state_s s);
    @(posedge pclk);
    err_state <= s;
  endtask : set_state
endmodule : ceif_engine

//--- bench/tb.sv
`timescale 1ns/1ns
module tb;
  import ceif_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [7:0] irq_flags;
  ceif_err_state_s err_state;
  ceif_events_s events;
  ceif_store_s store;
  int err_total, total_checks, cyc, flags_m, prev_m, mask_m, lst_m, b, f, s;
  int filt_m[32];
  int pos_m[6] = '{0, 1, 2, 3, 6, 7};

  ceif_status i_ceif_status (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .err_state, .events, .store, .irq_flags);
  ceif_engine i_ceif_engine (.pclk, .err_state, .events, .store);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  // Holds the request until pready is seen; the timeout ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(rd, e);
  endtask : rdchk

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(66));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFF_FLAGS, 0);
    for (int i = 0; i < 32; i++) rdchk(OFF_BUF_BASE + 12'(4 * i), 0);
    apb(1'b0, 12'h00C, 32'h00000000);
    chk({31'h0, perr}, 1);
    apb(1'b0, 12'h100, 32'h00000000);
    chk({31'h0, perr}, 1);
    chk(rd, 0);
    for (int i = 0; i < 12; i++) begin
      s = $urandom % 32;
      i_ceif_engine.set_state(5'(s));
      if ((s & ~prev_m) != 0) flags_m |= 32'h20;
      prev_m = s;
      apb(1'b1, OFF_FLAGS, 32'h0000FFFF);
      rdchk(OFF_FLAGS, (s << 9) | (((s & 3) != 0) ? 32'h100 : 0) | flags_m);
    end
    i_ceif_engine.set_state(5'h00);
    for (int i = 0; i < 6; i++) begin
      i_ceif_engine.pulse(ceif_events_s'(6'(1 << i)));
      rdchk(OFF_FLAGS, flags_m | (1 << pos_m[i]));
      chk(32'(irq_flags), flags_m | (1 << pos_m[i]));
      apb(1'b1, OFF_FLAGS, ~(32'h1 << pos_m[i]));
      rdchk(OFF_FLAGS, flags_m);
    end
    // An event that lands on the clearing write edge must survive it
    fork
      begin
        @(posedge pclk);
        i_ceif_engine.pulse(ceif_events_s'(6'h20));
      end
      apb(1'b1, OFF_FLAGS, 32'h00000000);
    join
    rdchk(OFF_FLAGS, 32'h00000080);
    apb(1'b1, OFF_FLAGS, 32'h00000000);
    rdchk(OFF_FLAGS, 0);
    mask_m = $urandom;
    apb(1'b1, OFF_TX_MASK, mask_m);
    rdchk(OFF_TX_MASK, mask_m);
    for (int i = 0; i < 16; i++) begin
      b = $urandom % 32;
      f = $urandom % 32;
      i_ceif_engine.put(5'(b), 5'(f));
      if (!mask_m[b]) begin
        filt_m[b] = f;
        lst_m = 32'h00010000 | (b << 8) | f;
      end
      rdchk(OFF_BUF_BASE + 12'(4 * b), filt_m[b] << 8);
    end
    rdchk(OFF_LAST_STORE, lst_m);
    apb(1'b1, OFF_LAST_STORE, 32'h00000000);
    rdchk(OFF_LAST_STORE, lst_m & 32'h0000FFFF);
    apb(1'b1, OFF_BUF_LAST, 32'hFFFFFFFF);
    rdchk(OFF_BUF_LAST, 32'h00001F00);
    // Reset again in mid-run with every event flag raised
    i_ceif_engine.pulse(ceif_events_s'(6'h3F));
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFF_FLAGS, 0);
    chk(32'(irq_flags), 0);
    rdchk(OFF_BUF_LAST, 0);
    print_verdict();
  end
endmodule : tb
